// >>> hdl/stepper_indexer_pwm_control.sv
`timescale 1ns/1ps
`include "motor_ctrl_cfg.svh"
module stepper_indexer_pwm_control
  import motor_ctrl_pkg::*;
(
  input wire logic clk, // 10 MHz clock
  input wire logic arst_n, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic advancePin, // step advance input
  input wire logic directionPin, // direction input
  input wire logic phaseAInputOne, // direct mode bridge a in1
  input wire logic phaseAInputTwo, // direct mode bridge a in2
  input wire logic phaseBInputOne, // direct mode bridge b in1
  input wire logic phaseBInputTwo, // direct mode bridge b in2
  input wire logic lowPowerRequest_n, // sleep request, active low
  input wire logic [1:0] senseAbove, // per bridge scaled compare result
  input wire motor_ctrl_pkg::faults_s faultIn, // raw fault detections
  output motor_ctrl_pkg::bridge_s bridgeA, // bridge a pin drive
  output motor_ctrl_pkg::bridge_s bridgeB, // bridge b pin drive
  output logic highSideEnable, // gate drive enabled after wake
  output logic [7:0] refScale, // reference dac code
  output logic [1:0] senseGainSel, // sense amplifier gain select
  output logic [5:0] senseGain, // numeric gain 5..40
  output logic [1:0] decayMode, // decay for this chop cycle
  output logic [7:0] currentA, // indexer magnitude a
  output logic [7:0] currentB, // indexer magnitude b
  output logic signA, // current sign a, 1 negative
  output logic signB, // current sign b, 1 negative
  output logic errorIndicatorLow_n, // fault pin out level
  output logic errorIndicatorLowEn, // fault open-drain enable
  output logic lockupIndicatorLow_n, // stall pin out level
  output logic lockupIndicatorLowEn, // stall open-drain enable
  output logic backEmfOutput // stall flag as back-emf output
);
  import motor_ctrl_pkg::*;
  // ------------------------------------------------------------
  // registers and apb slave
  // ------------------------------------------------------------
  logic [31:0] ctrl_r;
  logic [31:0] off_r;
  logic [7:0] scale_r;
  faults_s stat_r;
  logic [3:0] statWord;
  logic [9:0] pos_r;
  logic wr;
  logic mapped;
  logic swAdvance;
  assign wr = psel && penable && pwrite;
  assign pready = 1'b1;
  always_comb begin
    unique case (paddr)
      `OFS_CTRL, `OFS_OFFTIME, `OFS_SCALE, `OFS_STATUS,
      `OFS_POSITION: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !mapped;
  assign swAdvance = wr && paddr == `OFS_CTRL
                     && pwdata[`CTRL_SWADV_BIT];
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= `CTRL_RST;
      off_r <= `OFF_RST;
      scale_r <= `SCALE_RST;
    end else if (wr) begin
      unique case (paddr)
        // software advance bit is self clearing
        `OFS_CTRL: ctrl_r <= pwdata & ~(32'h1 << `CTRL_SWADV_BIT);
        `OFS_OFFTIME: off_r <= pwdata;
        `OFS_SCALE: scale_r <= pwdata[7:0];
        default: ;
      endcase
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `OFS_CTRL: prdata <= ctrl_r;
        `OFS_OFFTIME: prdata <= off_r;
        `OFS_SCALE: prdata <= {24'h000000, scale_r};
        `OFS_STATUS: prdata <= {28'h0000000, statWord};
        `OFS_POSITION: prdata <= {22'h000000, pos_r};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end
  // ------------------------------------------------------------
  // faults: sticky bits, write one to clear, set wins
  // ------------------------------------------------------------
  logic stallDet;
  faults_s evt;
  logic [3:0] clr;
  faults_s clrMask;
  always_comb begin
    evt = faultIn;
    evt.stall = stallDet;
    clr = (wr && paddr == `OFS_STATUS) ? pwdata[3:0] : 4'h0;
    // software sees the cfg bit order, not the struct packing
    clrMask.overCurrent = clr[`STAT_OCP_BIT];
    clrMask.overTemp = clr[`STAT_OTS_BIT];
    clrMask.underVolt = clr[`STAT_UVLO_BIT];
    clrMask.stall = clr[`STAT_STALL_BIT];
    statWord = 4'h0;
    statWord[`STAT_OCP_BIT] = stat_r.overCurrent;
    statWord[`STAT_OTS_BIT] = stat_r.overTemp;
    statWord[`STAT_UVLO_BIT] = stat_r.underVolt;
    statWord[`STAT_STALL_BIT] = stat_r.stall;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stat_r <= '0;
    end else begin
      stat_r <= faults_s'(evt | (stat_r & ~clrMask));
    end
  end
  always_comb begin
    errorIndicatorLow_n = 1'b0;
    errorIndicatorLowEn = |{stat_r.overCurrent, stat_r.overTemp,
                            stat_r.underVolt};
    lockupIndicatorLow_n = 1'b0;
    lockupIndicatorLowEn = stat_r.stall;
  end
  // stall enable gates stall detection; stall only while microstepping
  assign stallDet = ctrl_r[`CTRL_STALLEN_BIT] && faultIn.stall
                    && !off_r[`OFF_DIRECT_BIT];
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      backEmfOutput <= 1'b0;
    end else begin
      backEmfOutput <= stat_r.stall;
    end
  end
  // ------------------------------------------------------------
  // wake timer
  // ------------------------------------------------------------
  logic [13:0] wake_r;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wake_r <= 14'h0000;
      highSideEnable <= 1'b0;
    end else if (!lowPowerRequest_n) begin
      wake_r <= 14'h0000;
      highSideEnable <= 1'b0;
    end else if (!highSideEnable) begin
      if (wake_r == 14'(`WAKE_CYC - 1)) begin
        highSideEnable <= 1'b1;
      end else begin
        wake_r <= wake_r + 14'h0001;
      end
    end
  end
  // ------------------------------------------------------------
  // indexer
  // ------------------------------------------------------------
  logic advPrev_r;
  logic stepEvt;
  logic forward;
  logic revNow;
  logic [3:0] res;
  logic [9:0] stepSize;
  logic [9:0] alignMask;
  logic [9:0] basePos;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      advPrev_r <= 1'b0;
    end else begin
      advPrev_r <= advancePin;
    end
  end
  assign stepEvt = (advancePin && !advPrev_r) || swAdvance;
  // a control write that also advances steps with the reverse bit it writes
  assign revNow = (wr && paddr == `OFS_CTRL) ? pwdata[`CTRL_REV_BIT]
                  : ctrl_r[`CTRL_REV_BIT];
  assign forward = directionPin ^ revNow;
  assign res = (ctrl_r[`CTRL_RES_LSB +: 4] > `MAX_RES) ? `MAX_RES
               : ctrl_r[`CTRL_RES_LSB +: 4];
  // full step table spans 256 entries per quarter cycle, offset 128
  always_comb begin
    stepSize = 10'(10'h100 >> res);
    alignMask = ~10'(stepSize - 10'h001);
  end
  always_comb begin
    // full step grid is the 45 degree points, others align to zero
    if (res == 4'h0) begin
      basePos = 10'(((pos_r - `HOME_POS) & alignMask) + `HOME_POS);
    end else begin
      basePos = pos_r & alignMask;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pos_r <= `HOME_POS;
    end else if (stepEvt) begin
      if (forward) begin
        pos_r <= 10'(basePos + stepSize);
      end else if (basePos != pos_r) begin
        pos_r <= basePos;
      end else begin
        pos_r <= 10'(basePos - stepSize);
      end
    end
  end
  // quarter-wave sine as a quadratic fit, exact at 0, 45 and 90 degrees
  function automatic logic [7:0] sinMag(input logic [9:0] p);
    logic [8:0] q;
    q = p[8] ? 9'(9'h100 - {1'b0, p[7:0]}) : {1'b0, p[7:0]};
    if (q[8]) begin
      sinMag = 8'hff;
    end else begin
      sinMag = 8'(((32'(q[7:0]) * 32'd120064)
               - (32'(q[7:0]) * 32'(q[7:0]) * 32'd214)) >> 16);
    end
  endfunction
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      currentA <= 8'h00;
      currentB <= 8'h00;
      signA <= 1'b0;
      signB <= 1'b0;
    end else begin
      currentA <= (res == 4'h0) ? 8'hb5 : sinMag(pos_r);
      currentB <= (res == 4'h0) ? 8'hb5 : sinMag(10'(pos_r + 10'h100));
      signA <= pos_r[9];
      signB <= pos_r[9] ^ pos_r[8];
    end
  end
  // ------------------------------------------------------------
  // current regulation and bridge drive
  // ------------------------------------------------------------
  logic directMode;
  logic [1:0] chopOff;
  logic inA1;
  logic inA2;
  logic inB1;
  logic inB2;
  assign directMode = off_r[`OFF_DIRECT_BIT];
  assign refScale = scale_r;
  assign senseGainSel = ctrl_r[`CTRL_GAIN_LSB +: 2];
  always_comb begin
    unique case (senseGainSel)
      2'b00: senseGain = 6'd5;
      2'b01: senseGain = 6'd10;
      2'b10: senseGain = 6'd20;
      2'b11: senseGain = 6'd40;
    endcase
  end
  // no current trend is tracked in either mode, so requested decay is used each cycle
  assign decayMode = ctrl_r[`CTRL_DECAY_LSB +: 2];
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gChop
      chop_timer uTimer (
        .clk(clk),
        .arst_n(arst_n),
        .trip(senseAbove[g]),
        .offLen(off_r[`OFF_LEN_LSB +: 8]),
        .offActive(chopOff[g])
      );
    end
  endgenerate
  always_comb begin
    if (directMode) begin
      {inA1, inA2} = {phaseAInputOne, phaseAInputTwo};
      {inB1, inB2} = {phaseBInputOne, phaseBInputTwo};
    end else begin
      inA1 = highSideEnable && !signA;
      inA2 = highSideEnable && signA;
      inB1 = highSideEnable && !signB;
      inB2 = highSideEnable && signB;
    end
  end
  bridge_map uMapA (
    .inOne(inA1),
    .inTwo(inA2),
    .chopOff(chopOff[0]),
    .drive(bridgeA)
  );
  bridge_map uMapB (
    .inOne(inB1),
    .inTwo(inB2),
    .chopOff(chopOff[1]),
    .drive(bridgeB)
  );
  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  home_reset_a: assert property (@(posedge clk)
    $rose(arst_n) |-> pos_r == `HOME_POS)
    else $error("indexer not at home after reset");
  step_move_a: assert property (@(posedge clk) disable iff (!arst_n)
    stepEvt && forward && res == 4'h3 && pos_r[4:0] == 5'h00
    |=> pos_r == 10'($past(pos_r) + 10'h020))
    else $error("forward eighth step wrong size");
  fault_pin_a: assert property (@(posedge clk) disable iff (!arst_n)
    faultIn.overTemp |=> errorIndicatorLowEn && stat_r.overTemp)
    else $error("fault not flagged");
  direct_map_a: assert property (@(posedge clk) disable iff (!arst_n)
    directMode && !chopOff[0] && phaseAInputOne && !phaseAInputTwo
    |-> bridgeA.outOne && !bridgeA.outTwo && bridgeA.outTwoEn)
    else $error("forward map wrong");
  hiz_map_a: assert property (@(posedge clk) disable iff (!arst_n)
    directMode && !phaseBInputOne && !phaseBInputTwo
    |-> !bridgeB.outOneEn && !bridgeB.outTwoEn)
    else $error("hi-z map wrong");
  chop_off_a: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(chopOff[0]) |-> !bridgeA.outOne && !bridgeA.outTwo)
    else $error("bridge on during off time");
  gain_code_a: assert property (@(posedge clk) disable iff (!arst_n)
    senseGainSel == 2'b10 |-> senseGain == 6'd20)
    else $error("gain decode wrong");
  wake_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    !lowPowerRequest_n |=> !highSideEnable [*3])
    else $error("gate drive enabled too soon");
  status_sticky_a: assert property (@(posedge clk) disable iff (!arst_n)
    stat_r.underVolt && !clr[`STAT_UVLO_BIT] |=> stat_r.underVolt)
    else $error("status bit lost");
  cov_step_c: cover property (@(posedge clk) disable iff (!arst_n)
    stepEvt ##1 stepEvt);
  cov_direct_c: cover property (@(posedge clk) disable iff (!arst_n)
    directMode && $fell(chopOff[1]));
  cov_wake_c: cover property (@(posedge clk) disable iff (!arst_n)
    $rose(highSideEnable));
endmodule

// >>> hdl/motor_ctrl_cfg.svh
`ifndef MOTOR_CTRL_CFG_SVH
`define MOTOR_CTRL_CFG_SVH
// register byte offsets
`define OFS_CTRL 12'h000
`define OFS_OFFTIME 12'h004
`define OFS_SCALE 12'h008
`define OFS_STATUS 12'h00c
`define OFS_POSITION 12'h010
// control register fields
`define CTRL_SWADV_BIT 0
`define CTRL_REV_BIT 1
`define CTRL_RES_LSB 2
`define CTRL_GAIN_LSB 6
`define CTRL_DECAY_LSB 8
`define CTRL_STALLEN_BIT 10
// off-time register fields
`define OFF_LEN_LSB 0
`define OFF_DIRECT_BIT 8
// status register fields
`define STAT_OCP_BIT 0
`define STAT_OTS_BIT 1
`define STAT_UVLO_BIT 2
`define STAT_STALL_BIT 3
// reset values
`define CTRL_RST 32'h0000_000c
`define OFF_RST 32'h0000_0030
`define SCALE_RST 8'hff
// indexer
`define HOME_POS 10'h080
`define MAX_RES 4'h8
// timing
`define CLK_NS 100
`define OFF_UNIT_NS 500
`define OFF_UNIT_CYC (((`OFF_UNIT_NS) + (`CLK_NS) - 1) / (`CLK_NS))
`define WAKE_NS 1000000
`define WAKE_CYC ((`WAKE_NS) / (`CLK_NS))
`endif

// >>> hdl/motor_ctrl_pkg.sv
package motor_ctrl_pkg;
  typedef enum logic [1:0] {BR_HIZ, BR_REV, BR_FWD, BR_LOW} bridge_e;
  typedef enum logic [1:0] {DEC_SLOW, DEC_FAST, DEC_MIXED, DEC_AUTO} decay_e;
  typedef struct packed {
    logic outOne;
    logic outTwo;
    logic outOneEn;
    logic outTwoEn;
  } bridge_s;
  typedef struct packed {
    logic overCurrent;
    logic overTemp;
    logic underVolt;
    logic stall;
  } faults_s;
endpackage

// >>> hdl/bridge_map.sv
`timescale 1ns/1ps
module bridge_map
  import motor_ctrl_pkg::*;
(
  input wire logic inOne, // input one of the pair
  input wire logic inTwo, // input two of the pair
  input wire logic chopOff, // off interval active
  output motor_ctrl_pkg::bridge_s drive // output pin drive
);
  // ------------------------------------------------------------
  // pair decode
  // ------------------------------------------------------------
  bridge_e st;
  always_comb begin
    unique case ({inOne, inTwo})
      2'b00: st = BR_HIZ;
      2'b01: st = BR_REV;
      2'b10: st = BR_FWD;
      2'b11: st = BR_LOW;
    endcase
    // off interval recirculates through low sides
    if (chopOff && (st == BR_FWD || st == BR_REV)) begin
      st = BR_LOW;
    end
  end
  always_comb begin
    drive.outOne = (st == BR_FWD);
    drive.outTwo = (st == BR_REV);
    drive.outOneEn = (st != BR_HIZ);
    drive.outTwoEn = (st != BR_HIZ);
  end
endmodule

// >>> hdl/chop_timer.sv
`timescale 1ns/1ps
`include "motor_ctrl_cfg.svh"
module chop_timer
  import motor_ctrl_pkg::*;
(
  input wire logic clk, // 10 MHz clock
  input wire logic arst_n, // async reset, active low
  input wire logic trip, // comparator above threshold
  input wire logic [7:0] offLen, // off-time field
  output logic offActive // bridge held off
);
  logic [15:0] cnt_r;
  logic [15:0] target;
  // field value n gives (n+1) units of 500 ns, 500 ns to 128 us
  always_comb target = 16'((({8'h00, offLen} + 16'h0001)
                        * 16'(`OFF_UNIT_CYC)) - 16'h0001);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= 16'h0000;
      offActive <= 1'b0;
    end else if (trip && !offActive) begin
      cnt_r <= target;
      offActive <= 1'b1;
    end else if (offActive) begin
      if (cnt_r == 16'h0000) begin
        offActive <= 1'b0;
      end else begin
        cnt_r <= cnt_r - 16'h0001;
      end
    end
  end
  offtime_len_a: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(offActive) |-> offActive [*5])
    else $error("off interval shorter than one unit");
endmodule

// >>> dv/step_host.sv
`timescale 1ns/1ps
module step_host (
  input wire logic clk, // bench clock
  input wire logic arst_n, // async reset, active low
  input wire logic go, // request one advance pulse
  output logic advancePin, // advance pulse to the device
  output logic busy // pulse or its low time in progress
);
  // ----------------------------------------
  // pulse shaping
  // ----------------------------------------
  // 20 cycles high then 20 low: 2 us each, 4 us period, so 250 kHz max
  int cnt;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 0;
      advancePin <= 1'b0;
    end else begin
      if (cnt == 0 && go) cnt <= 40;
      else if (cnt != 0) cnt <= cnt - 1;
      advancePin <= (cnt > 20);
    end
  end
  assign busy = (cnt != 0);
endmodule

// >>> dv/stepper_indexer_pwm_control_bench.sv
`timescale 1ns/1ps
module stepper_indexer_pwm_control_bench;
  import motor_ctrl_pkg::*;
  logic clk, arst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic advancePin, directionPin, go, busy, lowPowerRequest_n;
  logic [3:0] phaseIn;
  logic [1:0] senseAbove, senseGainSel, decayMode;
  faults_s faultIn;
  bridge_s bridgeA, bridgeB;
  logic highSideEnable, signA, signB, errLvl, errEn, lockLvl, lockEn, back_emf_output;
  logic [7:0] refScale, currentA, currentB;
  logic [5:0] senseGain;
  logic [15:0] lfsrVal;
  logic [32:0] expQ[$];
  logic [9:0] pos;
  int bad_count, num_checks, cyc;

  stepper_indexer_pwm_control DUT (.clk(clk), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .advancePin(advancePin), .directionPin(directionPin),
    .phaseAInputOne(phaseIn[3]), .phaseAInputTwo(phaseIn[2]),
    .phaseBInputOne(phaseIn[1]), .phaseBInputTwo(phaseIn[0]),
    .lowPowerRequest_n(lowPowerRequest_n), .senseAbove(senseAbove),
    .faultIn(faultIn), .bridgeA(bridgeA), .bridgeB(bridgeB),
    .highSideEnable(highSideEnable), .refScale(refScale),
    .senseGainSel(senseGainSel), .senseGain(senseGain),
    .decayMode(decayMode), .currentA(currentA), .currentB(currentB),
    .signA(signA), .signB(signB), .errorIndicatorLow_n(errLvl),
    .errorIndicatorLowEn(errEn), .lockupIndicatorLow_n(lockLvl),
    .lockupIndicatorLowEn(lockEn), .backEmfOutput(back_emf_output));
  step_host host (.clk(clk), .arst_n(arst_n), .go(go),
    .advancePin(advancePin), .busy(busy));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) cyc <= 0;
    else cyc <= cyc + 1;
  end

  // ----------------------------------------
  // checking and reporting
  // ----------------------------------------
  task automatic chk_bus(input string what, input logic [32:0] e, g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk_pin(input string what, input logic [7:0] e, g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // read results are paired with the oldest note, in bus order
  always @(posedge clk) begin
    if (psel && penable && !pwrite && pready === 1'b1) begin
      if (expQ.size() == 0) chk_bus("stray read", 33'h0, {pslverr, prdata});
      else chk_bus("read data", expQ.pop_front(), {pslverr, prdata});
    end
  end
  initial begin
    #(30000 * 100);
    bad_count++;
    final_report();
  end

  // ----------------------------------------
  // drivers
  // ----------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    expQ.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic step_pin();
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    do begin
      @(posedge clk);
    end while (busy);
  endtask
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // both enables low means high impedance, levels then do not matter
  function automatic logic [7:0] seen(input bridge_s b);
    return {4'h0, b[3:2] & {2{|b[1:0]}}, b[1:0]};
  endfunction
  function automatic logic [7:0] want(input logic [1:0] p);
    case (p)
      2'b00: return 8'h00;
      2'b01: return 8'h07;
      2'b10: return 8'h0b;
      default: return 8'h03;
    endcase
  endfunction
  task automatic chop(input logic [7:0] len, input int expLow);
    int low;
    low = 0;
    apb(1'b1, 12'h004, 32'h100 | len);
    @(posedge clk);
    senseAbove <= 2'b01;
    @(posedge clk);
    senseAbove <= 2'b00;
    repeat (60) begin
      @(negedge clk);
      if (bridgeA.outOne === 1'b0) low++;
    end
    chk_pin("off length", 8'h01, 8'(low >= expLow - 1 && low <= expLow + 1));
    chk_pin("bridge back on", 8'h0b, seen(bridgeA));
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    arst_n = 1'b0;
    {psel, penable, pwrite, go} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    {phaseIn, senseAbove} = 6'h00;
    faultIn = '0;
    directionPin = 1'b1;
    lowPowerRequest_n = 1'b1;
    lfsrVal = 16'h7c6f;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (100) @(posedge clk);
    rd(12'h000, 33'h0000_000c);
    rd(12'h004, 33'h0000_0030);
    rd(12'h008, 33'h0000_00ff);
    rd(12'h00c, 33'h0);
    rd(12'h010, 33'h0000_0080);
    rd(12'h014, 33'h1_0000_0000);
    chk_pin("home current", 8'hb5, currentA);
    pos = 10'h080;
    for (int r = 0; r < 9; r++) begin
      apb(1'b1, 12'h000, 32'(r << 2));
      step_pin();
      pos = pos + (10'h100 >> r);
      rd(12'h010, {23'h0, pos});
      if (r == 0) chk_pin("signs", 8'h01, {6'h0, signA, signB});
    end
    apb(1'b1, 12'h000, 32'h0);
    step_pin();
    rd(12'h010, 33'h280);
    directionPin <= 1'b0;
    step_pin();
    rd(12'h010, 33'h180);
    apb(1'b1, 12'h000, 32'h3);
    rd(12'h010, 33'h280);
    apb(1'b1, 12'h008, 32'h5a);
    chk_pin("scale", 8'h5a, refScale);
    apb(1'b1, 12'h004, 32'h102);
    for (int i = 0; i < 4; i++) begin
      lfsrVal = lfsr_next(lfsrVal);
      apb(1'b1, 12'h000, 32'((i << 8) | (i << 6)));
      chk_pin("gain", 8'd5 << i, {2'h0, senseGain});
      chk_pin("gain code", 8'(i), {6'h0, senseGainSel});
      chk_pin("decay", 8'(i), {6'h0, decayMode});
      @(posedge clk);
      phaseIn <= {2'(i), lfsrVal[1:0]};
      @(negedge clk);
      chk_pin("bridge a", want(2'(i)), seen(bridgeA));
      chk_pin("bridge b", want(lfsrVal[1:0]), seen(bridgeB));
    end
    @(posedge clk);
    phaseIn <= 4'b1010;
    chop(8'h00, 5);
    chop(8'h05, 30);
    // microstep mode with stall reporting on, so the stall flag can set
    apb(1'b1, 12'h004, 32'h5);
    apb(1'b1, 12'h000, 32'h400);
    for (int f = 0; f < 4; f++) begin
      logic [7:0] pins;
      @(posedge clk);
      faultIn <= faults_s'(4'b1000 >> f);
      @(posedge clk);
      faultIn <= '0;
      repeat (2) @(negedge clk);
      pins = {3'h0, errLvl, errEn, lockLvl, lockEn, back_emf_output};
      chk_pin("fault pins", (f < 3) ? 8'h08 : 8'h03, pins);
      rd(12'h00c, 33'(1 << f));
      apb(1'b1, 12'h00c, 32'hf);
      chk_pin("fault pin clear", 8'h00, {6'h0, errEn, lockEn});
    end
    while (cyc < 9990) @(posedge clk);
    @(negedge clk);
    chk_pin("wake early", 8'h00, {7'h0, highSideEnable});
    repeat (20) @(negedge clk);
    chk_pin("wake done", 8'h01, {7'h0, highSideEnable});
    chk_pin("step drive", 8'h07, seen(bridgeA));
    @(posedge clk);
    lowPowerRequest_n <= 1'b0;
    @(posedge clk);
    lowPowerRequest_n <= 1'b1;
    repeat (20) @(negedge clk);
    chk_pin("sleep drops drive", 8'h00, {7'h0, highSideEnable});
    chk_pin("sleep bridge", 8'h00, seen(bridgeA));
    chk_pin("reads left", 8'h00, 8'(expQ.size()));
    final_report();
  end
endmodule
